/* File: verilog/stm_pkg.sv */
package stm_pkg;

    // ------------------------------------------------
    // Widths
    // ------------------------------------------------
    localparam int STM_CNT_W = 10;
    localparam int STM_PER_W = 3;

    typedef logic [STM_CNT_W-1:0] stm_cnt_t;
    typedef logic [STM_PER_W-1:0] stm_per_t;

    // ------------------------------------------------
    // Operating modes
    // ------------------------------------------------
    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'b00,
        STM_MODE_CAP = 2'b01,
        STM_MODE_PWM = 2'b10,
        STM_MODE_TMR = 2'b11
    } stm_mode_t;

    // ------------------------------------------------
    // Output action codes
    // ------------------------------------------------
    localparam logic [1:0] STM_IO_00 = 2'h0;
    localparam logic [1:0] STM_IO_01 = 2'h1;
    localparam logic [1:0] STM_IO_10 = 2'h2;
    localparam logic [1:0] STM_IO_11 = 2'h3;

    // ------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------
    localparam int STM_PER_STEP = 128;
    localparam int STM_LOW_W = 7;
    localparam logic [STM_CNT_W:0] STM_FULL = 11'h400;
    localparam logic [STM_LOW_W-1:0] STM_LOW_ZERO = 7'h00;
    localparam stm_per_t STM_PER_ZERO = 3'h0;
    localparam stm_cnt_t STM_CNT_RST = 10'h000;
    localparam stm_cnt_t STM_COMPARE_A_VALUE_RST = 10'h000;
    localparam logic STM_FLAG_RST = 1'b0;
    localparam logic STM_ON_RST = 1'b0;
    localparam logic STM_PIN_RST = 1'b0;

endpackage

/* File: verilog/stm_timer.sv */
`timescale 1ns/10ps
// Overview of operation
// - Mode 00: clear on P or overflow, both flags
// - Clear select high: clear on A, A flag only
// - Compare mode: pin changes only on A match or counter_on rise
// - A match: none, low, high, or toggle
// - Counter_on rise restores pin initial level
// - Mode 11: like compare, pin not driven
// - PWM: clear select ignored, swap picks period
// - PWM: A and P matches raise flags
// - PWM: polarity, force or wave, invert
// - Swap 0: period 128 times code, duty A
// - Duty at or above period: fully active
// - Swap 1: period from A, duty from P
// - PWM counting continues while output forced
// - Single pulse: ext edge sets counter_on
// - Pulse ends on clear or A match
// - Single pulse: counter zeroed only on rise
// - Capture: pin edge copies counter, flags
// - Capture: free run, P match clears, flags
// - Capture with action 11: no capture
// - Capture sees pin edges even as outputs
// - On rise zero counter; fall holds count
// - Capture edge: rise, fall, both, off
// - PWM action: inactive, active, wave, pulse
// - Initial level: initial or active polarity
module stm_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic timer_tick,
    input wire stm_pkg::stm_mode_t mode_select,
    input wire logic [1:0] output_action,
    input wire logic initial_level,
    input wire logic output_invert,
    input wire logic period_duty_swap,
    input wire logic clear_select,
    input wire stm_pkg::stm_per_t period_bits,
    input wire logic counter_on_wr,
    input wire logic counter_on_wdata,
    input wire logic compare_a_wr,
    input wire stm_pkg::stm_cnt_t compare_a_wdata,
    input wire logic ext_clock_pin,
    input wire logic ext_edge_falling,
    input wire logic timer_pin_zero_in,
    input wire logic timer_pin_one_in,
    input wire logic match_a_clr,
    input wire logic match_p_clr,
    output logic counter_on,
    output stm_pkg::stm_cnt_t count_value,
    output stm_pkg::stm_cnt_t compare_a_value,
    output logic match_a_flag,
    output logic match_p_flag,
    output logic timer_pin_zero_out,
    output logic timer_pin_zero_oe,
    output logic timer_pin_one_out,
    output logic timer_pin_one_oe
);
    import stm_pkg::*;

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    logic on_r;
    logic on_nxt;
    logic on_prev_r;
    stm_cnt_t cnt_r;
    stm_cnt_t cnt_nxt;
    stm_cnt_t compare_a_value_r;
    stm_cnt_t compare_a_value_nxt;
    logic fa_r;
    logic fa_nxt;
    logic fp_r;
    logic fp_nxt;
    logic cmp_lvl_r;
    logic cmp_lvl_nxt;
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic oe_nxt;
    logic ext_prev_r;
    logic tp0_prev_r;
    logic tp1_prev_r;

    // ------------------------------------------------
    // Mode decode
    // ------------------------------------------------
    wire m_cmp = (mode_select == STM_MODE_CMP);
    wire m_tmr = (mode_select == STM_MODE_TMR);
    wire m_cap = (mode_select == STM_MODE_CAP);
    wire m_pwm_any = (mode_select == STM_MODE_PWM);
    wire m_spm = m_pwm_any && (output_action == STM_IO_11);
    wire m_pwm = m_pwm_any && !m_spm;
    wire m_cmp_like = m_cmp || m_tmr;

    // ------------------------------------------------
    // Counter step and comparators
    // ------------------------------------------------
    wire on_rise = on_r && !on_prev_r;
    wire step = on_r && !on_rise && timer_tick;
    wire [STM_CNT_W:0] cnt_inc = {1'b0, cnt_r} + 11'h001;
    wire per_zero = (period_bits == STM_PER_ZERO);
    wire p_top_hit = (cnt_inc[STM_CNT_W-1:STM_LOW_W] == period_bits) &&
                     (cnt_inc[STM_LOW_W-1:0] == STM_LOW_ZERO) &&
                     !cnt_inc[STM_CNT_W];
    wire p_full_hit = per_zero && (cnt_inc == STM_FULL);
    // Comparator P: counter top bits reach code, code 0 is overflow
    wire p_hit = step && (p_top_hit || p_full_hit);
    wire a_hit_raw = ({1'b0, compare_a_value_r} == cnt_inc);
    // Compare A of zero means full span in PWM mode, with or without swap
    wire a_full = (compare_a_value_r == STM_COMPARE_A_VALUE_RST) && (cnt_inc == STM_FULL);
    wire a_hit = step && (a_hit_raw || (m_pwm && a_full));

    // ------------------------------------------------
    // Counter clear selection
    // ------------------------------------------------
    wire clr_cmp = clear_select ? a_hit : p_hit;
    wire clr_pwm = period_duty_swap ? a_hit : p_hit;
    wire cnt_clr = (m_cmp_like && clr_cmp) ||
                   (m_pwm && clr_pwm) ||
                   (m_cap && p_hit);

    // ------------------------------------------------
    // Flag events
    // ------------------------------------------------
    wire cap_rise0 = timer_pin_zero_in && !tp0_prev_r;
    wire cap_fall0 = !timer_pin_zero_in && tp0_prev_r;
    wire cap_rise1 = timer_pin_one_in && !tp1_prev_r;
    wire cap_fall1 = !timer_pin_one_in && tp1_prev_r;
    wire any_rise = cap_rise0 || cap_rise1;
    wire any_fall = cap_fall0 || cap_fall1;
    logic cap_sel;
    always_comb begin
        case (output_action)
            STM_IO_00: cap_sel = any_rise;
            STM_IO_01: cap_sel = any_fall;
            STM_IO_10: cap_sel = any_rise || any_fall;
            STM_IO_11: cap_sel = 1'b0;
            default: cap_sel = 1'b0;
        endcase
    end
    // Pin edges are seen even while the pin drives out
    wire cap_ev = m_cap && on_r && cap_sel;

    wire set_a = (m_cmp_like && a_hit) ||
                 (m_pwm && a_hit) ||
                 (m_spm && a_hit) ||
                 cap_ev;
    wire set_p = (m_cmp_like && !clear_select && p_hit) ||
                 (m_pwm && p_hit) ||
                 (m_cap && p_hit);

    // ------------------------------------------------
    // Single pulse trigger
    // ------------------------------------------------
    wire ext_rise = ext_clock_pin && !ext_prev_r;
    wire ext_fall = !ext_clock_pin && ext_prev_r;
    wire ext_act = ext_edge_falling ? ext_fall : ext_rise;
    wire spm_set = m_spm && ext_act;
    wire spm_end = m_spm && a_hit;

    // ------------------------------------------------
    // PWM duty
    // ------------------------------------------------
    wire [STM_CNT_W:0] per_duty = per_zero ? STM_FULL :
        {1'b0, period_bits, STM_LOW_ZERO};
    // Duty from compare A, or from period code when swapped
    wire [STM_CNT_W:0] duty_val = period_duty_swap ?
        per_duty : {1'b0, compare_a_value_r};
    // Count below duty is active; duty >= period stays active
    wire pwm_act = ({1'b0, cnt_r} < duty_val);

    // ------------------------------------------------
    // Active state chosen by output action
    // ------------------------------------------------
    logic act_sel;
    always_comb begin
        case (output_action)
            STM_IO_00: act_sel = 1'b0;
            STM_IO_01: act_sel = 1'b1;
            STM_IO_10: act_sel = pwm_act;
            STM_IO_11: act_sel = on_nxt;
            default: act_sel = 1'b0;
        endcase
    end
    // Initial level gives active polarity in PWM use
    wire pwm_lvl = initial_level ? act_sel : !act_sel;

    // ------------------------------------------------
    // Compare match pin action
    // ------------------------------------------------
    logic cmp_act;
    always_comb begin
        case (output_action)
            STM_IO_00: cmp_act = cmp_lvl_r;
            STM_IO_01: cmp_act = 1'b0;
            STM_IO_10: cmp_act = 1'b1;
            STM_IO_11: cmp_act = !cmp_lvl_r;
            default: cmp_act = cmp_lvl_r;
        endcase
    end

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        on_nxt = on_r;
        if (counter_on_wr) begin
            on_nxt = counter_on_wdata;
        end
        if (spm_set) begin
            on_nxt = 1'b1;
        end
        if (spm_end && !spm_set) begin
            on_nxt = 1'b0;
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (on_rise) begin
            cnt_nxt = STM_CNT_RST;
        end else if (step) begin
            if (cnt_clr) begin
                cnt_nxt = STM_CNT_RST;
            end else begin
                cnt_nxt = cnt_inc[STM_CNT_W-1:0];
            end
        end
    end

    always_comb begin
        compare_a_value_nxt = compare_a_value_r;
        if (compare_a_wr) begin
            compare_a_value_nxt = compare_a_wdata;
        end
        if (cap_ev) begin
            compare_a_value_nxt = cnt_r;
        end
    end

    // Set wins over a clear in the same cycle
    assign fa_nxt = set_a || (fa_r && !match_a_clr);
    assign fp_nxt = set_p || (fp_r && !match_p_clr);

    always_comb begin
        cmp_lvl_nxt = cmp_lvl_r;
        if (m_cmp && on_rise) begin
            cmp_lvl_nxt = initial_level;
        end else if (m_cmp && a_hit) begin
            cmp_lvl_nxt = cmp_act;
        end
    end

    always_comb begin
        pin_nxt = STM_PIN_RST;
        oe_nxt = 1'b0;
        if (m_cmp) begin
            pin_nxt = cmp_lvl_nxt ^ output_invert;
            oe_nxt = 1'b1;
        end else if (m_pwm_any) begin
            pin_nxt = pwm_lvl ^ output_invert;
            oe_nxt = 1'b1;
        end
    end

    // ------------------------------------------------
    // Registers
    // ------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            on_r <= STM_ON_RST;
            on_prev_r <= STM_ON_RST;
            cnt_r <= STM_CNT_RST;
            compare_a_value_r <= STM_COMPARE_A_VALUE_RST;
        end else begin
            on_r <= on_nxt;
            on_prev_r <= on_r;
            cnt_r <= cnt_nxt;
            compare_a_value_r <= compare_a_value_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fa_r <= STM_FLAG_RST;
            fp_r <= STM_FLAG_RST;
            cmp_lvl_r <= STM_PIN_RST;
            pin_r <= STM_PIN_RST;
            oe_r <= 1'b0;
        end else begin
            fa_r <= fa_nxt;
            fp_r <= fp_nxt;
            cmp_lvl_r <= cmp_lvl_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_r <= 1'b0;
            tp0_prev_r <= 1'b0;
            tp1_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= ext_clock_pin;
            tp0_prev_r <= timer_pin_zero_in;
            tp1_prev_r <= timer_pin_one_in;
        end
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign counter_on = on_r;
    assign count_value = cnt_r;
    assign compare_a_value = compare_a_value_r;
    assign match_a_flag = fa_r;
    assign match_p_flag = fp_r;
    assign timer_pin_zero_out = pin_r;
    assign timer_pin_zero_oe = oe_r;
    assign timer_pin_one_out = pin_r;
    assign timer_pin_one_oe = oe_r;

endmodule

/* File: bench/stm_timer_chk.sv */
`timescale 1ns/10ps
// ----------------
// Timer port checks
// ----------------
module stm_timer_chk
    import stm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire stm_pkg::stm_mode_t mode_select,
    input wire logic [1:0] output_action,
    input wire logic clear_select,
    input wire logic counter_on_wr,
    input wire logic compare_a_wr,
    input wire logic match_a_clr,
    input wire logic match_p_clr,
    input wire logic counter_on,
    input wire stm_pkg::stm_cnt_t count_value,
    input wire stm_pkg::stm_cnt_t compare_a_value,
    input wire logic match_a_flag,
    input wire logic match_p_flag,
    input wire logic timer_pin_zero_oe,
    input wire logic timer_pin_one_oe
);
    logic cap_off;
    logic clr_a;
    logic no_pin;
    assign cap_off = mode_select == STM_MODE_CAP && output_action == STM_IO_11;
    assign clr_a = clear_select && (mode_select == STM_MODE_CMP || mode_select == STM_MODE_TMR);
    assign no_pin = mode_select == STM_MODE_TMR || mode_select == STM_MODE_CAP;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_a_sticky: assert property (match_a_flag && !match_a_clr |=> match_a_flag)
        else $error("A flag lost");
    a_p_sticky: assert property (match_p_flag && !match_p_clr |=> match_p_flag)
        else $error("P flag lost");
    a_rise_zero: assert property ($rose(counter_on) |=> count_value == STM_CNT_RST)
        else $error("count not zeroed at start");
    a_off_hold: assert property (!counter_on && !$past(counter_on) |-> $stable(count_value))
        else $error("count moved while off");
    a_pin_free: assert property (no_pin && $stable(mode_select) |-> !timer_pin_zero_oe && !timer_pin_one_oe)
        else $error("pin driven in timer or capture mode");
    a_no_pflag: assert property (!match_p_flag && clr_a && $past(clr_a) |=> !match_p_flag)
        else $error("P flag with clear on A");
    a_cap_off: assert property (cap_off && $past(cap_off) && $past(cap_off, 2) && !compare_a_wr |=> $stable(compare_a_value))
        else $error("capture while disabled");
    a_pulse_end: assert property (mode_select == STM_MODE_PWM && output_action == STM_IO_11 && $fell(counter_on)
        && !$past(counter_on_wr) |-> match_a_flag)
        else $error("pulse stop without A flag");
endmodule

bind stm_timer stm_timer_chk u_chk (.mclk, .rst_n, .mode_select, .output_action, .clear_select, .counter_on_wr,
    .compare_a_wr, .match_a_clr, .match_p_clr, .counter_on, .count_value, .compare_a_value, .match_a_flag,
    .match_p_flag, .timer_pin_zero_oe, .timer_pin_one_oe);

/* File: bench/stm_pin_src.sv */
`timescale 1ns/10ps
// ----------------
// Far-side pin level
// ----------------
module stm_pin_src (
    input wire logic drv,
    input wire logic oe,
    input wire logic out,
    output logic lvl
);
    assign lvl = oe ? out : drv;
endmodule

/* File: bench/standard_timer_modes_test.sv */
`timescale 1ns/10ps
module standard_timer_modes_test;
    import stm_pkg::*;
    logic mclk, rst_n, timer_tick, initial_level, output_invert, period_duty_swap, clear_select, counter_on_wr;
    logic counter_on_wdata, compare_a_wr, ext_clock_pin, ext_edge_falling, timer_pin_zero_in, timer_pin_one_in;
    logic match_a_clr, match_p_clr, counter_on, match_a_flag, match_p_flag, timer_pin_zero_out, timer_pin_zero_oe;
    logic timer_pin_one_out, timer_pin_one_oe, d0, d1;
    logic [1:0] output_action;
    stm_mode_t mode_select;
    stm_per_t period_bits;
    stm_cnt_t compare_a_wdata, count_value, compare_a_value, seen;
    int fail_count, compares, hi;

    stm_timer dut (.mclk, .rst_n, .timer_tick, .mode_select, .output_action, .initial_level, .output_invert,
        .period_duty_swap, .clear_select, .period_bits, .counter_on_wr, .counter_on_wdata, .compare_a_wr,
        .compare_a_wdata, .ext_clock_pin, .ext_edge_falling, .timer_pin_zero_in, .timer_pin_one_in, .match_a_clr,
        .match_p_clr, .counter_on, .count_value, .compare_a_value, .match_a_flag, .match_p_flag,
        .timer_pin_zero_out, .timer_pin_zero_oe, .timer_pin_one_out, .timer_pin_one_oe);
    stm_pin_src src0 (.drv(d0), .oe(timer_pin_zero_oe), .out(timer_pin_zero_out), .lvl(timer_pin_zero_in));
    stm_pin_src src1 (.drv(d1), .oe(timer_pin_one_oe), .out(timer_pin_one_out), .lvl(timer_pin_one_in));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(string name, logic [9:0] exp, logic [9:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wait_for(ref logic s, input logic v, input int n);
        repeat (n) begin
            if (s === v) break;
            step(1);
        end
    endtask

    task automatic cfg(stm_mode_t m, logic [1:0] act, logic lvl, logic inv, logic swp, logic clr, stm_per_t per,
        stm_cnt_t a, logic run);
        @(posedge mclk);
        {counter_on_wr, compare_a_wr, match_a_clr, match_p_clr} <= 4'hF;
        counter_on_wdata <= 1'b0;
        compare_a_wdata <= a;
        {mode_select, output_action, initial_level, output_invert} <= {m, act, lvl, inv};
        {period_duty_swap, clear_select, period_bits} <= {swp, clr, per};
        @(posedge mclk);
        {compare_a_wr, match_a_clr, match_p_clr} <= 3'h0;
        counter_on_wdata <= run;
        @(posedge mclk);
        counter_on_wr <= 1'b0;
        #1;
    endtask

    task automatic cmp_case(logic [1:0] act, logic lvl, logic hit);
        cfg(STM_MODE_CMP, act, lvl, 1'b0, 1'b0, 1'b0, 3'h1, 10'h005, 1'b1);
        step(2);
        chk("pin initial", lvl, timer_pin_zero_out);
        wait_for(match_a_flag, 1'b1, 20);
        step(2);
        chk("pin on A match", hit, timer_pin_zero_out);
        chk("pin one on A match", hit, timer_pin_one_out);
        wait_for(match_p_flag, 1'b1, 140);
        chk("P flag", 1, match_p_flag);
        chk("count cleared", 1, count_value < 10'h004);
        chk("A flag kept", 1, match_a_flag);
        chk("pin at P match", hit, timer_pin_zero_out);
    endtask

    task automatic pwm_case(logic swp, stm_cnt_t a, logic [1:0] act, logic lvl, logic inv, int n, int exp);
        cfg(STM_MODE_PWM, act, lvl, inv, swp, 1'b1, 3'h1, a, 1'b1);
        step(20);
        hi = 0;
        repeat (n) begin
            step(1);
            hi += int'(timer_pin_zero_out === 1'b1);
        end
        chk("pwm active cycles", 10'(exp), 10'(hi));
        // A match exists when swapped, or when compare A lies inside the 128 clock period
        chk("pwm flags", {swp || (a < 10'(STM_PER_STEP)), 1'b1}, {match_a_flag, match_p_flag});
    endtask

    task automatic pin_set(logic one, logic v);
        @(posedge mclk);
        match_a_clr <= 1'b1;
        @(posedge mclk);
        match_a_clr <= 1'b0;
        if (one) begin
            d1 <= v;
        end else begin
            d0 <= v;
        end
        step(6);
    endtask

    task automatic cap_case(logic [1:0] act, logic one, logic on_rise, logic on_fall);
        cfg(STM_MODE_CAP, act, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 10'h000, 1'b1);
        step(20);
        seen = count_value;
        pin_set(one, 1'b1);
        chk("capture on rise", on_rise, match_a_flag);
        if (on_rise) chk("captured count", 1, compare_a_value - seen < 10'h008);
        pin_set(one, 1'b0);
        chk("capture on fall", on_fall, match_a_flag);
    endtask

    task automatic t_pulse(logic fall);
        @(posedge mclk);
        ext_edge_falling <= fall;
        ext_clock_pin <= fall;
        cfg(STM_MODE_PWM, STM_IO_11, 1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 10'h014, 1'b0);
        @(posedge mclk);
        ext_clock_pin <= !fall;
        wait_for(counter_on, 1'b1, 8);
        chk("trigger", 1, counter_on);
        step(1);
        chk("pulse lead", 1, timer_pin_zero_out);
        wait_for(counter_on, 1'b0, 40);
        chk("pulse A flag", 1, match_a_flag);
        step(8);
        chk("pulse trail", 0, {counter_on, timer_pin_zero_out});
        chk("count kept", 10'h014, count_value);
        @(posedge mclk);
        ext_clock_pin <= fall;
    endtask

    task automatic finish_test();
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        {rst_n, initial_level, output_invert, period_duty_swap, clear_select, counter_on_wr, d0, d1} = '0;
        {counter_on_wdata, compare_a_wr, ext_clock_pin, ext_edge_falling, match_a_clr, match_p_clr} = '0;
        {timer_tick, output_action, period_bits, compare_a_wdata} = {1'b1, 15'h0};
        mode_select = STM_MODE_CMP;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        step(1);
        chk("reset state", 0, {count_value[6:0], match_a_flag, match_p_flag, counter_on});
        cmp_case(STM_IO_11, 1'b0, 1'b1);
        cmp_case(STM_IO_01, 1'b1, 1'b0);
        cmp_case(STM_IO_10, 1'b0, 1'b1);
        cmp_case(STM_IO_00, 1'b1, 1'b1);
        cfg(STM_MODE_TMR, STM_IO_11, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1, 10'h005, 1'b1);
        step(300);
        chk("pin released", 0, {timer_pin_zero_oe, timer_pin_one_oe});
        chk("flags clear on A", 2'h2, {match_a_flag, match_p_flag});
        chk("count bound", 1, count_value <= 10'h005);
        cfg(STM_MODE_TMR, STM_IO_11, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 10'h005, 1'b1);
        step(1000);
        chk("count past top code", 1, count_value > 10'h380);
        wait_for(match_p_flag, 1'b1, 40);
        chk("flags on overflow", 2'h3, {match_a_flag, match_p_flag});
        chk("count after overflow", 1, count_value < 10'h004);
        pwm_case(1'b0, 10'h020, STM_IO_10, 1'b1, 1'b0, 256, 64);
        pwm_case(1'b0, 10'h0C8, STM_IO_10, 1'b1, 1'b0, 256, 256);
        pwm_case(1'b0, 10'h020, STM_IO_10, 1'b1, 1'b1, 256, 192);
        pwm_case(1'b0, 10'h020, STM_IO_10, 1'b0, 1'b0, 256, 192);
        pwm_case(1'b0, 10'h020, STM_IO_00, 1'b1, 1'b0, 256, 0);
        pwm_case(1'b0, 10'h020, STM_IO_01, 1'b1, 1'b0, 256, 256);
        pwm_case(1'b1, 10'h100, STM_IO_10, 1'b1, 1'b0, 512, 256);
        t_pulse(1'b0);
        t_pulse(1'b1);
        cap_case(STM_IO_00, 1'b0, 1'b1, 1'b0);
        cap_case(STM_IO_01, 1'b1, 1'b0, 1'b1);
        cap_case(STM_IO_10, 1'b0, 1'b1, 1'b1);
        cap_case(STM_IO_11, 1'b1, 1'b0, 1'b0);
        step(100);
        chk("capture P flag", 1, match_p_flag);
        chk("capture wrap", 1, count_value < 10'h080);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        finish_test();
    end
endmodule
